// ==== inc/sbg_clk_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sbg_clk_if;
    logic en;
    logic src_en;
    logic [2:0] pd_sel;
    logic [4:0] ins_sel;
    logic [1:0] bpd_sel;
    logic [2:0] bd_sel;
    logic presc_en;
    logic rt_tick;
    logic bit_tick;
    modport presc (input en, src_en, pd_sel, ins_sel, output presc_en);
    modport div (input en, presc_en, bpd_sel, bd_sel,
                 output rt_tick, bit_tick);
    modport top (output en, src_en, pd_sel, ins_sel, bpd_sel, bd_sel,
                 input presc_en, rt_tick, bit_tick);
endinterface
`default_nettype wire

// ==== inc/sbg_pkg.sv ====
`default_nettype none
package sbg_pkg;
    // apb map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h010;
    localparam logic [11:0] ADDR_STAT = 12'h014;
    localparam logic [11:0] ADDR_DATA = 12'h018;
    localparam logic [11:0] ADDR_BAUD = 12'h01c;
    localparam logic [11:0] ADDR_PSC = 12'h020;
    // baud_select fields
    localparam int BAUD_LIN_TX_BREAK_LENGTHEN = 7;
    localparam int BAUD_LIN_RX_BREAK_LENGTHEN = 6;
    localparam int BAUD_BPD_LSB = 4;
    localparam int BAUD_BD_LSB = 0;
    // fine_prescaler_select fields
    localparam int PSC_PD_LSB = 5;
    localparam int PSC_INS_LSB = 0;
    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_M = 1;
    localparam int CTRL_SRC = 2;
    localparam int CTRL_SEND_BRK = 3;
    // status fields
    localparam int STAT_BRK = 0;
    localparam int STAT_RXF = 1;
    localparam int STAT_TXB = 2;
    localparam int STAT_LEN_LSB = 4;
    // reset values
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] PSC_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // divider chain
    localparam int RT_PER_BIT = 16;
    localparam int RT_PRE_LOG2 = 2;
    localparam logic [3:0] RT_LAST = 4'hf;
    // break lengths in bit times
    localparam logic [3:0] RX_BRK_NORM = 4'ha;
    localparam logic [3:0] RX_BRK_LIN = 4'hb;
    localparam logic [3:0] TX_BRK_NORM = 4'ha;
    localparam logic [3:0] TX_BRK_LIN = 4'hd;

    typedef enum logic [1:0] {
        SBG_TX_IDLE = 2'b01,
        SBG_TX_BRK = 2'b10
    } sbg_tx_state_t;

    function automatic logic [3:0] sbg_bpd(input logic [1:0] sel);
        case (sel)
            2'b00: sbg_bpd = 4'h1;
            2'b01: sbg_bpd = 4'h3;
            2'b10: sbg_bpd = 4'h4;
            default: sbg_bpd = 4'hd;
        endcase
    endfunction

    // break length: base for the mode plus one for 9-bit words
    function automatic logic [3:0] sbg_brk_len(input logic [3:0] base,
                                               input logic m);
        sbg_brk_len = base + {3'h0, m};
    endfunction
endpackage
`default_nettype wire

// ==== logic/sbg_baud_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbg_baud_div
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divider chain
    sbg_clk_if.div cif
);
    logic [12:0] cnt_q, cnt_d;
    logic [3:0] rt_q, rt_d;
    logic [12:0] lim;
    logic rt;

    always_comb begin
        lim = (13'(sbg_bpd(cif.bpd_sel)) <<
               (4'(cif.bd_sel) + 4'(RT_PRE_LOG2))) - 13'h1;
        rt = cif.presc_en && (cnt_q == lim);
        cnt_d = cnt_q;
        rt_d = rt_q;
        if (!cif.en) begin
            cnt_d = 13'h0;
            rt_d = 4'h0;
        end else if (rt) begin
            cnt_d = 13'h0;
            rt_d = rt_q + 4'h1;
        end else if (cif.presc_en) begin
            cnt_d = cnt_q + 13'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 13'h0;
            rt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
            rt_q <= rt_d;
        end
    end

    assign cif.rt_tick = rt;
    assign cif.bit_tick = rt && (rt_q == RT_LAST);
endmodule
`default_nettype wire

// ==== logic/sbg_fine_presc.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbg_fine_presc
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divider chain
    sbg_clk_if.presc cif
);
    logic [3:0] cnt_q, cnt_d;
    logic [4:0] acc_q, acc_d;
    logic ext_q, ext_d;
    logic [5:0] acc_sum;
    logic [3:0] lim;
    logic wrap;

    always_comb begin
        lim = {1'b0, cif.pd_sel} + {3'h0, ext_q};
        wrap = cif.src_en && (cnt_q == lim);
        acc_sum = {1'b0, acc_q} + {1'b0, cif.ins_sel};
        cnt_d = cnt_q;
        acc_d = acc_q;
        ext_d = ext_q;
        if (!cif.en || cif.pd_sel == 3'h0) begin
            cnt_d = 4'h0;
            acc_d = 5'h0;
            ext_d = 1'b0;
        end else if (wrap) begin
            // period is pd_sel plus one input clocks, one more on a carry
            cnt_d = 4'h0;
            acc_d = acc_sum[4:0];
            ext_d = acc_sum[5];
        end else if (cif.src_en) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            acc_q <= 5'h0;
            ext_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            ext_q <= ext_d;
        end
    end

    // bypass skips both the divider and the insertion
    assign cif.presc_en = (cif.pd_sel == 3'h0) ? cif.src_en : wrap;
endmodule
`default_nettype wire

// ==== logic/sbg_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbg_top
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock source pin
    input wire logic osc_reference_clock,
    // line
    input wire logic rx_line,
    output logic tx_break_low,
    // shift register side
    input wire logic rx_load,
    input wire logic [7:0] rx_byte,
    output logic tx_load,
    output logic [7:0] tx_data_bits,
    // timing to shift registers
    output logic rt_tick,
    output logic bit_tick
);
    sbg_clk_if cif ();

    logic [7:0] baud_select_q, baud_select_d;
    logic [7:0] fine_prescaler_select_q, fine_prescaler_select_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [7:0] rx_data_bits_q, rx_data_bits_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic [31:0] prdata_q, prdata_d;
    logic tx_load_q, tx_load_d;
    logic brk_det_q, brk_det_d;
    logic rx_full_q, rx_full_d;
    logic [1:0] osc_s_q, rx_s_q;
    logic osc_old_q;
    logic [7:0] low_q, low_d;
    logic armed_q, armed_d;
    logic [3:0] meas_q, meas_d;
    sbg_tx_state_t tx_st_q, tx_st_d;
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic setup, wr, rd, hit;
    logic module_enable_bit, word_mode, baud_clock_source_sel;
    logic lin_tx_break_lengthen, lin_rx_break_lengthen;
    logic [3:0] rx_len, tx_len;
    logic rx_low, send_brk;

    assign module_enable_bit = ctrl_q[CTRL_EN];
    assign word_mode = ctrl_q[CTRL_M];
    assign baud_clock_source_sel = ctrl_q[CTRL_SRC];
    assign lin_tx_break_lengthen = baud_select_q[BAUD_LIN_TX_BREAK_LENGTHEN];
    assign lin_rx_break_lengthen = baud_select_q[BAUD_LIN_RX_BREAK_LENGTHEN];

    // apb decode
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    always_comb begin
        hit = 1'b1;
        if (paddr == ADDR_CTRL) begin
            hit = 1'b1;
        end else if (paddr == ADDR_STAT) begin
            hit = 1'b1;
        end else if (paddr == ADDR_DATA) begin
            hit = 1'b1;
        end else if (paddr == ADDR_BAUD) begin
            hit = 1'b1;
        end else if (paddr == ADDR_PSC) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign send_brk = wr && paddr == ADDR_CTRL && pwdata[CTRL_SEND_BRK];

    // registers
    always_comb begin
        baud_select_d = baud_select_q;
        fine_prescaler_select_d = fine_prescaler_select_q;
        ctrl_d = ctrl_q;
        if (wr && paddr == ADDR_BAUD) begin
            baud_select_d = pwdata[7:0];
        end
        if (wr && paddr == ADDR_PSC) begin
            fine_prescaler_select_d = pwdata[7:0];
        end
        if (wr && paddr == ADDR_CTRL) begin
            ctrl_d = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_select_q <= BAUD_RST;
            fine_prescaler_select_q <= PSC_RST;
            ctrl_q <= CTRL_RST[2:0];
        end else begin
            baud_select_q <= baud_select_d;
            fine_prescaler_select_q <= fine_prescaler_select_d;
            ctrl_q <= ctrl_d;
        end
    end

    // data buffer, no reset on purpose
    always_comb begin
        rx_data_bits_d = rx_data_bits_q;
        tx_data_d = tx_data_q;
        if (rx_load) begin
            rx_data_bits_d = rx_byte;
        end
        if (wr && paddr == ADDR_DATA) begin
            tx_data_d = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        rx_data_bits_q <= rx_data_bits_d;
        tx_data_q <= tx_data_d;
    end
    assign tx_data_bits = tx_data_q;

    // read data and flags
    always_comb begin
        prdata_d = prdata_q;
        tx_load_d = wr && paddr == ADDR_DATA;
        if (setup && !pwrite) begin
            prdata_d = 32'h0;
            if (paddr == ADDR_CTRL) begin
                prdata_d[2:0] = ctrl_q;
            end else if (paddr == ADDR_STAT) begin
                prdata_d[STAT_BRK] = brk_det_q;
                prdata_d[STAT_RXF] = rx_full_q;
                prdata_d[STAT_TXB] = tx_st_q == SBG_TX_BRK;
                prdata_d[STAT_LEN_LSB +: 4] = meas_q;
            end else if (paddr == ADDR_DATA) begin
                prdata_d[7:0] = rx_data_bits_q;
            end else if (paddr == ADDR_BAUD) begin
                prdata_d[7:0] = baud_select_q;
            end else if (paddr == ADDR_PSC) begin
                prdata_d[7:0] = fine_prescaler_select_q;
            end
        end
        // a new byte beats the clearing read
        rx_full_d = rx_load || (rx_full_q && !(rd && paddr == ADDR_DATA));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            tx_load_q <= 1'b0;
            rx_full_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            tx_load_q <= tx_load_d;
            rx_full_q <= rx_full_d;
        end
    end
    assign prdata = prdata_q;
    assign tx_load = tx_load_q;

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s_q <= 2'b00;
            rx_s_q <= 2'b11;
            osc_old_q <= 1'b0;
        end else begin
            osc_s_q <= {osc_s_q[0], osc_reference_clock};
            rx_s_q <= {rx_s_q[0], rx_line};
            osc_old_q <= osc_s_q[1];
        end
    end

    // clock source select and divider chain
    assign cif.en = module_enable_bit;
    assign cif.src_en = module_enable_bit && (!baud_clock_source_sel ||
        (osc_s_q[1] && !osc_old_q));
    assign cif.pd_sel = fine_prescaler_select_q[PSC_PD_LSB +: 3];
    assign cif.ins_sel = fine_prescaler_select_q[PSC_INS_LSB +: 5];
    assign cif.bpd_sel = baud_select_q[BAUD_BPD_LSB +: 2];
    assign cif.bd_sel = baud_select_q[BAUD_BD_LSB +: 3];

    // prescaler with evenly spread insertion, then bpd, bd and 64
    sbg_fine_presc u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );
    sbg_baud_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );
    // one rate for both directions
    assign rt_tick = cif.rt_tick;
    assign bit_tick = cif.bit_tick;

    // break lengths by lin controls and word length
    always_comb begin
        rx_len = sbg_brk_len(RX_BRK_NORM, word_mode);
        tx_len = sbg_brk_len(TX_BRK_NORM, word_mode);
        if (lin_rx_break_lengthen && !lin_tx_break_lengthen) begin
            rx_len = sbg_brk_len(RX_BRK_LIN, word_mode);
        end
        if (lin_tx_break_lengthen) begin
            tx_len = sbg_brk_len(TX_BRK_LIN, word_mode);
            if (lin_rx_break_lengthen) begin
                rx_len = sbg_brk_len(RX_BRK_LIN, word_mode);
            end
        end
    end

    // receive break detector, counted in rt ticks
    assign rx_low = !rx_s_q[1];
    always_comb begin
        low_d = low_q;
        armed_d = armed_q;
        meas_d = meas_q;
        brk_det_d = brk_det_q;
        if (rd && paddr == ADDR_DATA) begin
            brk_det_d = 1'b0;
        end
        if (!module_enable_bit) begin
            low_d = 8'h0;
        end else if (rt_tick && rx_low) begin
            if (low_q != 8'hff) begin
                low_d = low_q + 8'h1;
            end
            if (armed_q && low_q == {rx_len, 4'h0} - 8'h1) begin
                brk_det_d = 1'b1;
                armed_d = 1'b0;
            end
        end else if (rt_tick) begin
            if (!armed_q && low_q != 8'h0) begin
                meas_d = low_q[7:4];
            end
            low_d = 8'h0;
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 8'h0;
            armed_q <= 1'b0;
            meas_q <= 4'h0;
            brk_det_q <= 1'b0;
        end else begin
            low_q <= low_d;
            armed_q <= armed_d;
            meas_q <= meas_d;
            brk_det_q <= brk_det_d;
        end
    end

    // transmit break generator
    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        case (tx_st_q)
            SBG_TX_IDLE: begin
                tx_cnt_d = 4'h0;
                if (send_brk && module_enable_bit) begin
                    tx_st_d = SBG_TX_BRK;
                end
            end
            SBG_TX_BRK: begin
                if (!module_enable_bit) begin
                    tx_st_d = SBG_TX_IDLE;
                end else if (bit_tick) begin
                    tx_cnt_d = tx_cnt_q + 4'h1;
                    if (tx_cnt_q == tx_len - 4'h1) begin
                        tx_st_d = SBG_TX_IDLE;
                    end
                end
            end
            default: begin
                tx_st_d = SBG_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q <= SBG_TX_IDLE;
            tx_cnt_q <= 4'h0;
        end else begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end
    assign tx_break_low = tx_st_q == SBG_TX_BRK;
endmodule
`default_nettype wire

// ==== tb/sbg_line_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbg_line_node (
    // clock
    input wire logic pclk,
    // line
    output logic rx_line
);
    initial rx_line = 1'b1;
    // idle line is high; a low stretch is a break or an all-zero char
    task automatic hold_low(input int cycles);
        @(posedge pclk);
        rx_line <= 1'b0;
        repeat (cycles) @(posedge pclk);
        rx_line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb/sbg_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbg_top_sva
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs
    input wire logic tx_break_low,
    input wire logic tx_load,
    input wire logic [7:0] tx_data_bits,
    input wire logic rt_tick,
    input wire logic bit_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped, acc, rd_su, data_wr, brk_wr;
    assign mapped = paddr inside {ADDR_CTRL, ADDR_STAT, ADDR_DATA,
        ADDR_BAUD, ADDR_PSC};
    assign acc = psel && penable;
    assign rd_su = psel && !penable && !pwrite;
    assign data_wr = acc && pwrite && paddr == ADDR_DATA;
    assign brk_wr = acc && pwrite && paddr == ADDR_CTRL &&
        pwdata[CTRL_SEND_BRK];
    chk_apb_ready: assert property (pready)
        else $error("pready low");
    chk_err_map: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong");
    chk_rd_unmapped: assert property (rd_su && !mapped |=>
        prdata == 32'h0) else $error("unmapped read not zero");
    chk_rd_upper: assert property (rd_su && (paddr == ADDR_BAUD ||
        paddr == ADDR_PSC) |=> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_tx_load_on: assert property (data_wr |=> tx_load &&
        tx_data_bits == $past(pwdata[7:0])) else $error("tx load wrong");
    chk_tx_load_src: assert property (tx_load |-> $past(data_wr))
        else $error("tx load without write");
    chk_brk_start: assert property ($rose(tx_break_low) |->
        $past(brk_wr)) else $error("break without request");
    chk_bit_on_rt: assert property (bit_tick |-> rt_tick)
        else $error("bit tick off rt tick");
    chk_rt_space: assert property (rt_tick |=> !rt_tick [*3])
        else $error("rt ticks too close");
    chk_bit_space: assert property (bit_tick |=> !bit_tick [*8])
        else $error("bit ticks too close");
endmodule
bind sbg_top sbg_top_sva chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_break_low(tx_break_low), .tx_load(tx_load),
    .tx_data_bits(tx_data_bits), .rt_tick(rt_tick), .bit_tick(bit_tick));
`default_nettype wire

// ==== tb/sci_baud_gen_and_lin_break_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sci_baud_gen_and_lin_break_tb_top import sbg_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, rx_line, rx_load;
    logic pready, pslverr, tx_break_low, tx_load, rt_tick, bit_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [7:0] rx_byte, tx_data_bits, b8, p8;
    logic [1:0] osc_div = 2'h0;
    int fail_count, samples_checked, n, cyc, len, bv;
    sbg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_reference_clock(osc_div[1]), .rx_line(rx_line),
        .tx_break_low(tx_break_low), .rx_load(rx_load), .rx_byte(rx_byte),
        .tx_load(tx_load), .tx_data_bits(tx_data_bits), .rt_tick(rt_tick),
        .bit_tick(bit_tick));
    sbg_line_node node_u (.pclk(pclk), .rx_line(rx_line));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) osc_div <= osc_div + 2'h1;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // pclk cycles spanned by eight rt ticks for a setting
    function automatic int exp_rate(input logic [7:0] b,
                                    input logic [7:0] p);
        int baud_pre_divisor, pd;
        case (b[5:4])
            2'b00: baud_pre_divisor = 1;
            2'b01: baud_pre_divisor = 3;
            2'b10: baud_pre_divisor = 4;
            default: baud_pre_divisor = 13;
        endcase
        pd = (p[7:5] == 3'h0) ? 32 : 32 * (p[7:5] + 1) + p[4:0];
        return baud_pre_divisor * (1 << b[2:0]) * pd;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [7:0] b, input logic [7:0] p,
                       input logic [3:0] c);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_BAUD, {24'h0, b});
        apb(1'b1, ADDR_PSC, {24'h0, p});
        apb(1'b1, ADDR_CTRL, {28'h0, c});
    endtask
    // cycles spanned by eight rt ticks
    task automatic span8();
        int k;
        k = -1;
        cyc = 0;
        while (k < 8 && cyc < 60000) begin
            @(negedge pclk);
            if (k >= 0) cyc++;
            if (rt_tick === 1'b1) k++;
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, rx_load} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rx_byte = 8'h00;
        presetn = 1'b0;
        seed = 32'h72d6;
        fail_count = 0;
        samples_checked = 0;
        do_reset();
        apb(1'b0, ADDR_BAUD, 32'h0);
        check("baud rst", rd, 32'h0);
        apb(1'b0, ADDR_PSC, 32'h0);
        check("psc rst", rd, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("test reset done");
        // divider chain: every prescaler, random fine settings
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            p8 = seed[15:8];
            if (i == 0) p8[7:5] = 3'h0;
            if (i == 5) p8 = 8'hff;
            b8 = {seed[23:22], i[1:0], seed[3], 2'b00, seed[0]};
            if (i == 6) begin
                b8[2:0] = 3'h7;
                p8[7:5] = 3'h0;
            end
            cfg(b8, p8, 4'h1);
            apb(1'b0, ADDR_BAUD, 32'h0);
            check("baud rw", rd, {24'h0, b8});
            apb(1'b0, ADDR_PSC, 32'h0);
            check("psc rw", rd, {24'h0, p8});
            span8();
            check("rate", cyc, exp_rate(b8, p8));
        end
        cfg(8'h00, 8'h00, 4'h5);
        span8();
        check("osc rate", cyc, 128);
        $display("test rate done");
        // break generation, normal and lengthened
        for (int j = 0; j < 4; j++) begin
            cfg({j[1], j[1], 6'h0}, 8'h00, {2'b00, j[0], 1'b1});
            apb(1'b1, ADDR_CTRL, {28'h0, 2'b10, j[0], 1'b1});
            len = j[1] ? 13 + j[0] : 10 + j[0];
            n = 0;
            bv = 0;
            for (int c = 0; c < 2000; c++) begin
                @(negedge pclk);
                if (bv == 1 && tx_break_low !== 1'b1) break;
                if (tx_break_low === 1'b1) bv = 1;
                if (tx_break_low === 1'b1 && bit_tick === 1'b1) n++;
            end
            check("tx break", n, len);
        end
        $display("test break tx done");
        // break detection just under and just over the length
        for (int j = 0; j < 6; j++) begin
            cfg({j >= 4, j >= 2, 6'h0}, 8'h00, {2'b00, j[0], 1'b1});
            len = j >= 2 ? 11 + j[0] : 10 + j[0];
            repeat (200) @(posedge pclk);
            apb(1'b0, ADDR_DATA, 32'h0);
            node_u.hold_low((len - 1) * 64);
            repeat (200) @(posedge pclk);
            apb(1'b0, ADDR_STAT, 32'h0);
            check("no brk", rd[STAT_BRK], 1'b0);
            node_u.hold_low((len + 1) * 64 + 32);
            repeat (200) @(posedge pclk);
            apb(1'b0, ADDR_STAT, 32'h0);
            check("brk", rd[STAT_BRK], 1'b1);
            check("brk len", rd[STAT_LEN_LSB +: 4], len + 1);
        end
        $display("test break rx done");
        // data buffer both ways, kept over a second reset
        seed = xs(seed);
        apb(1'b1, ADDR_DATA, seed);
        @(negedge pclk);
        check("tx data", tx_data_bits, seed[7:0]);
        @(posedge pclk);
        rx_byte <= seed[15:8];
        rx_load <= 1'b1;
        @(posedge pclk);
        rx_load <= 1'b0;
        apb(1'b0, ADDR_STAT, 32'h0);
        check("rx full", rd[STAT_RXF], 1'b1);
        apb(1'b0, ADDR_DATA, 32'h0);
        check("rx data", rd, {24'h0, seed[15:8]});
        do_reset();
        apb(1'b0, ADDR_DATA, 32'h0);
        check("rx kept", rd, {24'h0, seed[15:8]});
        check("tx kept", tx_data_bits, seed[7:0]);
        apb(1'b0, ADDR_BAUD, 32'h0);
        check("baud rst2", rd, 32'h0);
        $display("test buffer done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
